// [design/lmsr_defines.vh]
// Purpose: constants for the loop master status register bank
// Assumes: 16-bit registers, zero-based locations
// Notes: included by every design file
`ifndef LMSR_DEFINES_VH
`define LMSR_DEFINES_VH
// host function codes served
`define LMSR_FC_READ_COILS 8'h01
`define LMSR_FC_READ_HOLD 8'h03
`define LMSR_FC_READ_INPUT 8'h04
// register locations
`define LMSR_LOC_STATUS 16'h0000
`define LMSR_LOC_SCAN_UPPER 16'h0001
`define LMSR_LOC_BAUD 16'h0002
`define LMSR_LOC_SCAN_COUNT 16'h0003
`define LMSR_LOC_FAULT 16'h0004
`define LMSR_LOC_ADDR_FAULT 16'h0005
`define LMSR_LOC_PROGRESS 16'h0006
`define LMSR_LOC_FOUND 16'h0007
`define LMSR_NUM_REGS 16'h0008
`define LMSR_NUM_DISCRETES 16'h0010
// status word bit positions
`define LMSR_ST_LB_PROGRESS 0
`define LMSR_ST_LB_IN_USE 1
`define LMSR_ST_UNIT_ALARM 2
`define LMSR_ST_ACT_ALARM 3
`define LMSR_ST_SIDE_B 4
`define LMSR_ST_SHUTDOWN 5
`define LMSR_ST_PRIMARY 7
`define LMSR_ST_START_FAIL 8
`define LMSR_ST_POR 10
`define LMSR_ST_WDOG 11
`define LMSR_ST_AUTO_LB 12
`define LMSR_ST_COMMS_FAIL 13
`define LMSR_ST_A_OK 14
`define LMSR_ST_B_OK 15
// fault code limits
`define LMSR_FTYPE_OPEN 4'h5
`define LMSR_FTYPE_SHORT 4'h6
`define LMSR_CAUSE_MAX 8'h09
`define LMSR_STEP_MAX 4'h9
// number of field units and logical stations
`define LMSR_NUM_UNITS 8
`define LMSR_NUM_STATIONS 4
`define LMSR_ZERO16 16'h0000
`define LMSR_ONE16 16'h0001
`endif

// [design/lmsr_alarm_or.v]
// Purpose: common field unit alarm from per-unit alarm bits
// Assumes: offline units arrive separately on unit_offline_i and are or-ed in here
// Notes: registered or-reduction
`timescale 1ns/1ps
`include "lmsr_defines.vh"
module lmsr_alarm_or (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // per-unit alarm and offline flags
  input wire [`LMSR_NUM_UNITS-1:0] unit_alarm_i,
  input wire [`LMSR_NUM_UNITS-1:0] unit_offline_i,
  // common alarm
  output reg common_alarm_o
);
  wire [`LMSR_NUM_UNITS-1:0] any_unit;
  genvar g;
  // per unit: alarm or offline counts as alarm
  generate
    for (g = 0; g < `LMSR_NUM_UNITS; g = g + 1) begin : g_unit
      assign any_unit[g] = unit_alarm_i[g] | unit_offline_i[g];
    end
  endgenerate
  // registered common alarm
  always @(posedge clk_i) begin
    if (srst_i) begin
      common_alarm_o <= 1'b0;
    end else begin
      common_alarm_o <= |any_unit;
    end
  end
endmodule

// [design/lmsr_scan_counter.v]
// Purpose: loop scan counter and current scan address
// Assumes: scan_step_i pulses once per field unit polled
// Notes: wraps to address one after the upper address
`timescale 1ns/1ps
`include "lmsr_defines.vh"
module lmsr_scan_counter (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // scan control
  input wire scan_step_i,
  input wire [7:0] upper_addr_i,
  // results
  output reg [15:0] scan_count_o,
  output reg [7:0] scan_addr_o
);
  // advance address, count a full pass at the upper address
  always @(posedge clk_i) begin
    if (srst_i) begin
      scan_count_o <= `LMSR_ZERO16;
      scan_addr_o <= 8'h01;
    end else if (scan_step_i) begin
      if (scan_addr_o >= upper_addr_i) begin
        scan_addr_o <= 8'h01;
        scan_count_o <= scan_count_o + `LMSR_ONE16;
      end else begin
        scan_addr_o <= scan_addr_o + 8'h01;
      end
    end
  end
endmodule

// [design/lmsr_status_bank.v]
// Purpose: read-only status register bank of a field-loop master station
// Assumes: request is a decoded host read; station state arrives as inputs
// Notes: answers one cycle after a request; exceptions on bad code or range
`timescale 1ns/1ps
`include "lmsr_defines.vh"
module lmsr_status_bank (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // host read request
  input wire req_valid_i,
  input wire [1:0] req_station_i,
  input wire [7:0] req_func_i,
  input wire [15:0] req_loc_i,
  // station state flags
  input wire lb_progress_i,
  input wire lb_in_use_i,
  input wire act_alarm_i,
  input wire side_b_i,
  input wire shutdown_i,
  input wire primary_i,
  input wire start_fail_i,
  input wire por_i,
  input wire wdog_fail_i,
  input wire auto_lb_i,
  input wire comms_fail_i,
  input wire unit_a_ok_i,
  input wire unit_b_ok_i,
  input wire [`LMSR_NUM_UNITS-1:0] unit_alarm_i,
  input wire [`LMSR_NUM_UNITS-1:0] unit_offline_i,
  // loop data
  input wire [7:0] upper_addr_i,
  input wire [15:0] baud_code_i,
  input wire scan_step_i,
  input wire fault_port_b_i,
  input wire fault_dup_i,
  input wire fault_high_i,
  input wire fault_zero_i,
  input wire [3:0] fault_type_i,
  input wire [7:0] config_cause_i,
  input wire [7:0] fault_pos_i,
  input wire [7:0] fault_addr_i,
  input wire [3:0] config_step_i,
  input wire [7:0] found_a_i,
  input wire [7:0] found_b_i,
  // answer
  output reg rsp_valid_o,
  output reg rsp_error_o,
  output reg [15:0] rsp_data_o,
  output reg [7:0] scan_addr_o
);
  wire common_alarm;
  wire [15:0] scan_count;
  wire [7:0] scan_addr;
  reg [15:0] status_word;
  reg [15:0] fault_word;
  reg [15:0] reg_mux;
  reg [15:0] next_data;
  reg next_error;
  reg func_ok;
  reg is_bit;

  // common unit alarm
  lmsr_alarm_or u_alarm (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .unit_alarm_i(unit_alarm_i),
    .unit_offline_i(unit_offline_i),
    .common_alarm_o(common_alarm)
  );

  // scan counter
  lmsr_scan_counter u_scan (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .scan_step_i(scan_step_i),
    .upper_addr_i(upper_addr_i),
    .scan_count_o(scan_count),
    .scan_addr_o(scan_addr)
  );

  // assemble the status word
  always @* begin
    status_word = `LMSR_ZERO16;
    status_word[`LMSR_ST_LB_PROGRESS] = lb_progress_i;
    status_word[`LMSR_ST_LB_IN_USE] = lb_in_use_i;
    status_word[`LMSR_ST_UNIT_ALARM] = common_alarm;
    status_word[`LMSR_ST_ACT_ALARM] = act_alarm_i;
    status_word[`LMSR_ST_SIDE_B] = side_b_i;
    status_word[`LMSR_ST_PRIMARY] = primary_i;
    status_word[`LMSR_ST_SHUTDOWN] = shutdown_i;
    status_word[`LMSR_ST_START_FAIL] = start_fail_i;
    status_word[`LMSR_ST_POR] = por_i;
    status_word[`LMSR_ST_WDOG] = wdog_fail_i;
    status_word[`LMSR_ST_AUTO_LB] = auto_lb_i;
    status_word[`LMSR_ST_COMMS_FAIL] = comms_fail_i;
    status_word[`LMSR_ST_A_OK] = unit_a_ok_i;
    status_word[`LMSR_ST_B_OK] = unit_b_ok_i;
  end

  // assemble the loop fault word, out-of-range codes read zero
  always @* begin
    fault_word = `LMSR_ZERO16;
    fault_word[15] = fault_port_b_i;
    fault_word[14] = fault_dup_i;
    fault_word[13] = fault_high_i;
    fault_word[12] = fault_zero_i;
    if (fault_type_i == `LMSR_FTYPE_OPEN || fault_type_i == `LMSR_FTYPE_SHORT) begin
      fault_word[11:8] = fault_type_i;
    end
    if (config_cause_i <= `LMSR_CAUSE_MAX) begin
      fault_word[7:0] = config_cause_i;
    end
  end

  // register select by zero-based location
  always @* begin
    case (req_loc_i)
      `LMSR_LOC_STATUS: reg_mux = status_word;
      `LMSR_LOC_SCAN_UPPER: reg_mux = {8'h00, upper_addr_i};
      `LMSR_LOC_BAUD: reg_mux = baud_code_i;
      `LMSR_LOC_SCAN_COUNT: reg_mux = scan_count;
      `LMSR_LOC_FAULT: reg_mux = fault_word;
      `LMSR_LOC_ADDR_FAULT: reg_mux = {fault_pos_i, fault_addr_i};
      `LMSR_LOC_PROGRESS: begin
        if (config_step_i <= `LMSR_STEP_MAX) begin
          reg_mux = {12'h000, config_step_i};
        end else begin
          reg_mux = `LMSR_ZERO16;
        end
      end
      `LMSR_LOC_FOUND: reg_mux = {found_b_i, found_a_i};
      default: reg_mux = `LMSR_ZERO16;
    endcase
  end

  // decode function code and range; station number is ignored
  always @* begin
    func_ok = 1'b0;
    is_bit = 1'b0;
    case (req_func_i)
      `LMSR_FC_READ_COILS: begin
        func_ok = 1'b1;
        is_bit = 1'b1;
      end
      `LMSR_FC_READ_HOLD: func_ok = 1'b1;
      `LMSR_FC_READ_INPUT: func_ok = 1'b1;
      default: func_ok = 1'b0;
    endcase
    next_error = 1'b0;
    next_data = `LMSR_ZERO16;
    if (!func_ok) begin
      next_error = 1'b1;
    end else if (is_bit) begin
      if (req_loc_i < `LMSR_NUM_DISCRETES) begin
        next_data = {15'h0000, status_word[req_loc_i[3:0]]};
      end else begin
        next_error = 1'b1;
      end
    end else if (req_loc_i < `LMSR_NUM_REGS) begin
      next_data = reg_mux;
    end else begin
      next_error = 1'b1;
    end
  end

  // registered answer, one cycle after request
  always @(posedge clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_error_o <= 1'b0;
      rsp_data_o <= `LMSR_ZERO16;
      scan_addr_o <= 8'h00;
    end else begin
      rsp_valid_o <= req_valid_i;
      scan_addr_o <= scan_addr;
      if (req_valid_i) begin
        rsp_error_o <= next_error;
        rsp_data_o <= next_data;
      end
    end
  end
endmodule

// [dv/lmsr_status_bank_properties.sv]
// Purpose: answer timing and refusal checks
// Assumes: answer one cycle after a taken request
// Notes: bound below to the status bank
`timescale 1ns/1ps
module lmsr_status_bank_properties (
  // clock, reset, request and answer
  input wire clk_i,
  input wire srst_i,
  input wire req_valid_i,
  input wire [7:0] req_func_i,
  input wire [15:0] req_loc_i,
  input wire rsp_valid_o,
  input wire rsp_error_o,
  input wire [15:0] rsp_data_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // request kinds
  wire rd_reg = req_valid_i && (req_func_i == 8'h03 || req_func_i == 8'h04);
  wire rd_bit = req_valid_i && req_func_i == 8'h01;
  chk_answer_next: assert property (req_valid_i |=> rsp_valid_o)
    else $error("no answer");
  chk_no_stray: assert property (!req_valid_i |=> !rsp_valid_o)
    else $error("stray answer");
  chk_bad_code: assert property (req_valid_i && !rd_reg && !rd_bit |=>
    rsp_error_o && rsp_data_o == 16'h0000) else $error("bad code served");
  chk_reg_range: assert property (rd_reg && req_loc_i > 16'h0007 |=> rsp_error_o)
    else $error("register range");
  chk_bit_range: assert property (rd_bit && req_loc_i > 16'h000f |=> rsp_error_o)
    else $error("discrete range");
  chk_reg_served: assert property (rd_reg && req_loc_i < 16'h0008 |=> !rsp_error_o)
    else $error("register refused");
  chk_reserved_zero: assert property (rd_reg && req_loc_i == 16'h0000 |=>
    rsp_data_o[6] == 1'b0 && rsp_data_o[9] == 1'b0) else $error("reserved set");
  chk_bit_in_lsb: assert property (rd_bit && req_loc_i < 16'h0010 |=>
    !rsp_error_o && rsp_data_o[15:1] == 15'h0000) else $error("discrete shape");
  cov_refused: cover property (req_valid_i && !rd_reg && !rd_bit);
  cov_status: cover property (rd_reg && req_loc_i == 16'h0000);
  cov_discrete: cover property (rd_bit ##1 rsp_data_o[0]);
endmodule
bind lmsr_status_bank lmsr_status_bank_properties u_props (.clk_i(clk_i), .srst_i(srst_i),
  .req_valid_i(req_valid_i), .req_func_i(req_func_i), .req_loc_i(req_loc_i),
  .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o), .rsp_data_o(rsp_data_o));

// [dv/lmsr_host_model.sv]
// Purpose: host issuing zero-based reads
// Assumes: one request at a time
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module lmsr_host_model (
  // clock and request
  input wire clk_i,
  output reg req_valid_o,
  output reg [1:0] req_station_o,
  output reg [7:0] req_func_o,
  output reg [15:0] req_loc_o
);
  // idle at time zero
  initial begin
    req_valid_o = 1'b0;
    {req_station_o, req_func_o, req_loc_o} = 26'h0;
  end
  // drive after a falling edge, hold through the taking edge
  task rd(input [1:0] st, input [7:0] fc, input [15:0] loc);
    begin
      @(negedge clk_i);
      req_valid_o = 1'b1;
      req_station_o = st;
      req_func_o = fc;
      req_loc_o = loc;
      @(negedge clk_i);
      req_valid_o = 1'b0;
      {req_station_o, req_func_o, req_loc_o} = ~{st, fc, loc};
    end
  endtask
endmodule

// [dv/tb_loop_master_status_registers.sv]
// Purpose: random and corner reads of locations 0 to 17 with codes 01, 02, 03, 04 and 10
// Assumes: answer one cycle after a taken request
// Notes: expectations come from bench state only
`timescale 1ns/1ps
module tb_loop_master_status_registers;
  reg clk_i;
  reg srst_i;
  reg scan_step_i;
  reg [127:0] s;
  reg [31:0] seed;
  reg [15:0] scnt;
  reg [39:0] fcl;
  integer compares, miscompares, cyc, i, l, k;
  wire req_valid_i, rsp_valid_o, rsp_error_o;
  wire [1:0] req_station_i;
  wire [7:0] req_func_i, scan_addr_o;
  wire [15:0] req_loc_i, rsp_data_o;
  lmsr_host_model u_host (.clk_i(clk_i), .req_valid_o(req_valid_i),
    .req_station_o(req_station_i), .req_func_o(req_func_i), .req_loc_o(req_loc_i));
  lmsr_status_bank u_dut (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
    .req_station_i(req_station_i), .req_func_i(req_func_i), .req_loc_i(req_loc_i),
    .lb_progress_i(s[0]), .lb_in_use_i(s[1]), .act_alarm_i(s[2]), .side_b_i(s[3]),
    .shutdown_i(s[4]), .primary_i(s[5]), .start_fail_i(s[6]), .por_i(s[7]), .wdog_fail_i(s[8]),
    .auto_lb_i(s[9]), .comms_fail_i(s[10]), .unit_a_ok_i(s[11]), .unit_b_ok_i(s[12]),
    .unit_alarm_i(s[20:13] & {8{s[29]}}), .unit_offline_i(s[28:21] & {8{s[30]}}),
    .upper_addr_i(s[38:31]), .baud_code_i(s[54:39]), .scan_step_i(scan_step_i),
    .fault_port_b_i(s[58]), .fault_dup_i(s[57]), .fault_high_i(s[56]), .fault_zero_i(s[55]),
    .fault_type_i(s[62:59]), .config_cause_i({4'h0, s[66:63]}), .fault_pos_i(s[82:75]),
    .fault_addr_i(s[74:67]), .config_step_i(s[86:83]), .found_a_i(s[94:87]),
    .found_b_i(s[102:95]), .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o),
    .rsp_data_o(rsp_data_o), .scan_addr_o(scan_addr_o));
  always #5 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  function [31:0] xs();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  // error flag and data expected for one read
  function [16:0] expect_rsp(input [7:0] fc, input [15:0] loc);
    reg [15:0] st;
    begin
      st = {s[12:7], 1'b0, s[6:5], 1'b0, s[4:2],
        (s[29] && |s[20:13]) || (s[30] && |s[28:21]), s[1:0]};
      expect_rsp = 17'h10000;
      if (fc == 8'h01 && loc < 16'h0010)
        expect_rsp = {16'h0000, st[loc[3:0]]};
      if ((fc == 8'h03 || fc == 8'h04) && loc < 16'h0008) begin
        case (loc[2:0])
          3'h0: expect_rsp = {1'b0, st};
          3'h1: expect_rsp = {9'h000, s[38:31]};
          3'h2: expect_rsp = {1'b0, s[54:39]};
          3'h3: expect_rsp = {1'b0, scnt};
          3'h4: expect_rsp = {1'b0, s[58:55], (s[62:59] == 4'h5 || s[62:59] == 4'h6) ?
            s[62:59] : 4'h0, 4'h0, (s[66:63] > 4'h9) ? 4'h0 : s[66:63]};
          3'h5: expect_rsp = {1'b0, s[82:67]};
          3'h6: expect_rsp = {13'h0000, (s[86:83] > 4'h9) ? 4'h0 : s[86:83]};
          default: expect_rsp = {1'b0, s[102:87]};
        endcase
      end
    end
  endfunction
  task chk(input [8*12:1] what, input [17:0] exp, input [17:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task read_check(input [7:0] fc, input [15:0] loc);
    reg [31:0] r;
    begin
      r = xs();
      u_host.rd(r[1:0], fc, loc);
      chk("answer", {1'b1, expect_rsp(fc, loc)}, {rsp_valid_o, rsp_error_o, rsp_data_o});
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // reset, two scan passes, then random reads of every location
  initial begin
    clk_i = 1'b0;
    srst_i = 1'b1;
    scan_step_i = 1'b0;
    seed = 32'd35408;
    {compares, miscompares, cyc} = 96'h0;
    scnt = 16'h0000;
    fcl = 40'h1002040301;
    s = {xs(), xs(), xs(), xs()};
    s[38:31] = 8'h03;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    read_check(8'h03, 16'h0003);
    for (i = 0; i < 7; i = i + 1) begin
      @(negedge clk_i);
      scan_step_i = 1'b1;
      @(negedge clk_i);
      scan_step_i = 1'b0;
    end
    scnt = 16'h0002;
    read_check(8'h04, 16'h0003);
    chk("scan address", 18'h00002, {10'h000, scan_addr_o});
    for (i = 0; i < 60; i = i + 1) begin
      s = {xs(), xs(), xs(), xs()};
      repeat (2) @(negedge clk_i);
      for (l = 0; l < 18; l = l + 1)
        for (k = 0; k < 5; k = k + 1)
          read_check(fcl[k * 8 +: 8], l[15:0]);
    end
    tally_and_finish;
  end
endmodule
